//--- inc/usd_pkg.sv
/*
 Shared constants and types of the unprivileged-store and
 subtract-immediate decoder. Assumes instructions arrive whole,
 first halfword in bits 31:16, on the single core clock.
*/
// Behaviour
// [RULE1] 32-bit unprivileged store with base field 1111 is undefined.
// [RULE2] store address is base plus zero-extended 8-bit offset, no writeback.
// [RULE3] store with source register 13 or 15 is unpredictable.
// [RULE4] store writes all four bytes, always with unprivileged permission.
// [RULE5] 16-bit 3-bit-immediate subtract: 0001111, imm, source, destination.
// [RULE6] 3-bit immediate zero-extended; flags only outside a conditional block.
// [RULE7] 8-bit form shares source and destination; flags only outside block.
// [RULE8] 32-bit optional-flag form expands its immediate; flags when S set.
// [RULE9] that form: destination 1111 with S is compare; base 1101 is SP form.
// [RULE10] that form unpredictable: dest 13, dest 15 without S, base 15.
// [RULE11] wide form: 12-bit zero-extended, no flags; base 1111 or 1101 alias.
// [RULE12] wide form unpredictable when destination is 13 or 15.
// [RULE13] result is operand plus inverted immediate plus one; NZCV from it.
// [RULE14] store matched by 111110000100 and second halfword bits 11:8 1110.
// [RULE15] failed condition check updates no register, memory or flag.
// [RULE16] undefined cases go to the exception logic; unpredictable is safe.
package usd_pkg;
    // register map, byte addresses
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_FLAGS  = 8'h08;
    localparam logic [1:0] GPR_SEL    = 2'h1;  // 0x40..0x7c, one per reg
    localparam int         CTRL_STRICT = 0;
    localparam logic       CTRL_RST   = 1'h0;
    localparam logic [3:0] FLAGS_RST  = 4'h0;
    localparam int         FLG_N = 3;
    localparam int         FLG_Z = 2;
    localparam int         FLG_C = 1;
    localparam int         FLG_V = 0;
    localparam logic [1:0] BUS_ACK = 2'h2;
    // opcode fields
    localparam logic [6:0]  T1_OPC   = 7'h0f;
    localparam logic [4:0]  T2_OPC   = 5'h07;
    localparam logic [4:0]  W32_PFX  = 5'h1e;
    localparam logic [4:0]  T3_OPC   = 5'h0d;
    localparam logic [5:0]  T4_OPC   = 6'h2a;
    localparam logic [11:0] USTR_OPC = 12'hf84;
    localparam logic [3:0]  USTR_SUB = 4'he;
    localparam logic [3:0]  REG_PC   = 4'hf;
    localparam logic [3:0]  REG_SP   = 4'hd;
    localparam logic [3:0]  ALL_BYTES = 4'hf;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_EXEC  = 3'h2,
        ST_STORE = 3'h4
    } usd_state_t;
    typedef enum logic [1:0] {
        OP_NONE  = 2'h0,
        OP_STORE = 2'h1,
        OP_SUB   = 2'h2
    } usd_op_t;
    typedef enum logic [1:0] {
        AL_NONE = 2'h0,
        AL_COMP = 2'h1,
        AL_SP   = 2'h2,
        AL_ADR  = 2'h3
    } usd_alias_t;
endpackage

//--- inc/usd_dp_if.sv
/*
 Datapath bundle between the decoder core, its adder and its
 register file. Assumes all three sit on core_clk.
*/
`timescale 1ns/1ns
interface usd_dp_if;
    logic [31:0] a;
    logic [31:0] b;
    logic        sub;
    logic [31:0] sum;
    logic        carry;
    logic        ovf;
    logic [3:0]  ra_addr;
    logic [3:0]  rb_addr;
    logic [31:0] ra_q;
    logic [31:0] rb_q;
    logic        we;
    logic [3:0]  wa;
    logic [31:0] wd;
    modport core (output a, b, sub, ra_addr, rb_addr, we, wa, wd,
                  input sum, carry, ovf, ra_q, rb_q);
    modport alu  (input a, b, sub, output sum, carry, ovf);
    modport rf   (input ra_addr, rb_addr, we, wa, wd, output ra_q, rb_q);
endinterface

//--- core/usd_alu.sv
/*
 Adder of the decoder: a plus b, or a plus inverted b plus one.
 Assumes operands are stable for the whole execute cycle.
*/
`timescale 1ns/1ns
module usd_alu (
    usd_dp_if.alu dp
);
    logic [31:0] b_w;
    logic [32:0] full_w;

    // subtract reuses the adder with an inverted operand and carry-in
    assign b_w    = dp.sub ? ~dp.b : dp.b;  // [RULE13]
    assign full_w = {1'b0, dp.a} + {1'b0, b_w} + {32'h0, dp.sub};
    assign dp.sum   = full_w[31:0];
    assign dp.carry = full_w[32];
    assign dp.ovf   = (dp.a[31] == b_w[31]) && (full_w[31] != dp.a[31]);
endmodule

//--- core/usd_regfile.sv
/*
 Sixteen-entry core register file, two registered read ports and
 one write port. Assumes a write and a read of the same entry in
 one cycle return the old value.
*/
`timescale 1ns/1ns
module usd_regfile #(
    parameter int unsigned DEPTH = 16
) (
    input  wire logic core_clk,
    input  wire logic rst,
    usd_dp_if.rf      dp
);
    logic [31:0] mem_r [DEPTH];
    logic [31:0] qa_r;
    logic [31:0] qb_r;

    // storage carries no reset; contents are loaded by software
    always_ff @(posedge core_clk) begin
        if (dp.we) begin
            mem_r[dp.wa] <= dp.wd;
        end
    end

    // read data out of flops keeps the execute path short
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            qa_r <= 32'h0;
            qb_r <= 32'h0;
        end else begin
            qa_r <= mem_r[dp.ra_addr];
            qb_r <= mem_r[dp.rb_addr];
        end
    end

    assign dp.ra_q = qa_r;
    assign dp.rb_q = qb_r;
endmodule

//--- core/usd_top.sv
/*
 Decoder and executor of the unprivileged word store and the four
 subtract-immediate forms, with an Avalon-MM slave for control,
 status, flags and the register file. Assumes the fetch side holds
 an instruction until it is taken and a memory port that accepts
 a word store by valid and ready.
*/
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module usd_top
    import usd_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic [7:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              instr_valid,
    output logic                   instr_ready,
    input  wire logic [31:0]       instr_word,
    input  wire logic              instr_is32,
    input  wire logic              cond_pass,
    input  wire logic              in_conditional_block,
    output logic                   st_valid,
    input  wire logic              st_ready,
    output logic      [31:0]       st_addr,
    output logic      [31:0]       st_data,
    output logic      [3:0]        st_byte_en,
    output logic                   st_unpriv,
    output logic                   instr_done,
    output logic                   undef_trap,
    output logic                   unpred_seen,
    output logic                   alias_valid,
    output usd_pkg::usd_alias_t    alias_kind,
    output logic      [3:0]        condition_flags_register
);
    import usd_pkg::*;

    usd_dp_if dp();

    usd_alu u_alu (
        .dp (dp)
    );

    usd_regfile #(
        .DEPTH (16)
    ) u_rf (
        .core_clk (core_clk),
        .rst      (rst),
        .dp       (dp)
    );

    // rotate-based expansion of a 12-bit packed constant [RULE8]
    function automatic logic [31:0] modified_immediate_expand(
        input logic [11:0] v
    );
        logic [31:0] base;
        logic [63:0] dbl;
        logic [7:0]  b;
        b    = v[7:0];
        base = {24'h0, 1'b1, v[6:0]};
        dbl  = {base, base} >> v[11:7];
        if (v[11:10] != 2'h0) begin
            return dbl[31:0];
        end
        case (v[9:8])
            2'h0: return {24'h0, b};
            2'h1: return {8'h0, b, 8'h0, b};
            2'h2: return {b, 8'h0, b, 8'h0};
            2'h3: return {b, b, b, b};
        endcase
        return 32'h0;
    endfunction

    usd_state_t  state_r;
    usd_state_t  state_nxt;
    usd_op_t     op_r;
    usd_alias_t  alias_r;
    logic [3:0]  rd_r;
    logic [31:0] imm_r;
    logic        setf_r;
    logic        undef_r;
    logic        unpred_r;
    logic        cond_r;
    logic        ctrl_r;
    logic [3:0]  flags_r;
    logic        last_undef_r;
    logic        last_unpred_r;
    logic [1:0]  bus_cnt_r;
    logic [31:0] rdata_r;
    logic        st_valid_r;
    logic [31:0] st_addr_r;
    logic [31:0] st_data_r;
    logic        done_r;
    logic        undef_out_r;
    logic        unpred_out_r;
    logic        alias_vld_r;
    usd_alias_t  alias_out_r;

    // instruction field views
    logic [15:0] hw1;
    logic [15:0] hw2;
    logic [3:0]  w_fo;
    logic [3:0]  w_rd;
    logic [3:0]  w_sr;
    logic        w_s;
    logic [11:0] twelve_bit_immediate;
    assign hw1   = instr_word[31:16];
    assign hw2   = instr_word[15:0];
    assign w_fo  = hw1[3:0];
    assign w_rd  = hw2[11:8];
    assign w_sr  = hw2[15:12];
    assign w_s   = hw1[4];
    assign twelve_bit_immediate = {hw1[10], hw2[14:12], hw2[7:0]};

    // encoding match
    logic is_t1;
    logic is_t2;
    logic is_t3;
    logic is_t4;
    logic is_st;
    logic is_w32;
    assign is_w32 = instr_is32 && hw1[15:11] == W32_PFX && !hw2[15];
    assign is_t1  = !instr_is32 && hw1[15:9] == T1_OPC;  // [RULE5]
    assign is_t2  = !instr_is32 && hw1[15:11] == T2_OPC;
    assign is_t3  = is_w32 && hw1[9:5] == T3_OPC;
    assign is_t4  = is_w32 && hw1[9:4] == T4_OPC;
    assign is_st  = instr_is32 && hw1[15:4] == USTR_OPC
                    && hw2[11:8] == USTR_SUB;  // [RULE14]

    // operand and immediate selection
    logic [3:0]  dec_fo;
    logic [3:0]  dec_rd;
    logic [31:0] dec_imm;
    logic        dec_setf;
    usd_op_t     dec_op;
    assign dec_fo = is_t1 ? {1'b0, hw1[5:3]} :
                    is_t2 ? {1'b0, hw1[10:8]} : w_fo;  // [RULE7]
    assign dec_rd = is_t1 ? {1'b0, hw1[2:0]} :
                    is_t2 ? {1'b0, hw1[10:8]} : w_rd;
    assign dec_imm = is_t1 ? {29'h0, hw1[8:6]} :        // [RULE6]
                     is_t2 ? {24'h0, hw1[7:0]} :        // [RULE7]
                     is_t3 ? modified_immediate_expand(twelve_bit_immediate) :
                     is_t4 ? {20'h0, twelve_bit_immediate} : // [RULE11]
                     {24'h0, hw2[7:0]};                 // [RULE2]
    assign dec_setf = (is_t1 || is_t2) ? !in_conditional_block : // [RULE6]
                      is_t3 ? w_s : 1'b0;               // [RULE8] [RULE11]
    assign dec_op = is_st ? OP_STORE :
                    (is_t1 || is_t2 || is_t3 || is_t4) ? OP_SUB : OP_NONE;

    // redirects take precedence over the unpredictable checks
    usd_alias_t dec_alias;
    logic       dec_undef;
    logic       raw_unpred;
    logic       dec_unpred;
    assign dec_alias = (is_t3 && w_rd == REG_PC && w_s) ? AL_COMP : // [RULE9]
                       (is_t3 && w_fo == REG_SP) ? AL_SP :
                       (is_t4 && w_fo == REG_PC) ? AL_ADR :         // [RULE11]
                       (is_t4 && w_fo == REG_SP) ? AL_SP : AL_NONE;
    assign dec_undef = is_st && w_fo == REG_PC;  // [RULE1]
    assign raw_unpred =
        (is_st && (w_sr == REG_SP || w_sr == REG_PC)) ||          // [RULE3]
        (is_t3 && (w_rd == REG_SP || (w_rd == REG_PC && !w_s)
                   || w_fo == REG_PC)) ||                         // [RULE10]
        (is_t4 && (w_rd == REG_SP || w_rd == REG_PC));            // [RULE12]
    assign dec_unpred = raw_unpred && dec_alias == AL_NONE && !dec_undef;

    // bus decode; bus has priority over new instructions when idle
    logic idle;
    logic bus_req;
    logic bus_ack;
    logic sel_ctrl;
    logic sel_status;
    logic sel_flags;
    logic sel_gpr;
    logic acc;
    assign idle       = state_r == ST_IDLE;
    assign bus_req    = avs_read || avs_write;
    assign bus_ack    = bus_cnt_r == BUS_ACK;
    assign sel_ctrl   = avs_address == OFF_CTRL;
    assign sel_status = avs_address == OFF_STATUS;
    assign sel_flags  = avs_address == OFF_FLAGS;
    assign sel_gpr    = avs_address[7:6] == GPR_SEL;
    assign instr_ready = idle && !bus_req;
    assign acc        = instr_valid && instr_ready;
    assign avs_waitrequest = !bus_ack;

    // execute qualifiers
    logic exec;
    logic go;
    logic sub_wb;
    logic bus_wr;
    assign exec = state_r == ST_EXEC;
    assign go   = cond_r && !undef_r && !unpred_r      // [RULE15] [RULE16]
                  && alias_r == AL_NONE && op_r != OP_NONE;
    assign sub_wb = exec && go && op_r == OP_SUB;
    assign bus_wr = bus_ack && avs_write;

    // datapath hookup
    assign dp.ra_addr = (idle && bus_req) ? avs_address[5:2] : dec_fo;
    assign dp.rb_addr = w_sr;
    assign dp.a   = dp.ra_q;
    assign dp.b   = imm_r;
    assign dp.sub = op_r == OP_SUB;                    // [RULE13]
    assign dp.we  = sub_wb || (bus_wr && sel_gpr);
    assign dp.wa  = sub_wb ? rd_r : avs_address[5:2];
    assign dp.wd  = sub_wb ? dp.sum : avs_writedata;   // [RULE13]

    // sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:  if (acc) state_nxt = ST_EXEC;
            ST_EXEC:  state_nxt = (go && op_r == OP_STORE) ? ST_STORE
                                                           : ST_IDLE;
            ST_STORE: if (st_ready) state_nxt = ST_IDLE;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // decode capture; condition is sampled with the instruction
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            op_r     <= OP_NONE;
            alias_r  <= AL_NONE;
            rd_r     <= 4'h0;
            imm_r    <= 32'h0;
            setf_r   <= 1'b0;
            undef_r  <= 1'b0;
            unpred_r <= 1'b0;
            cond_r   <= 1'b0;
        end else if (acc) begin
            op_r     <= dec_op;
            alias_r  <= dec_alias;
            rd_r     <= dec_rd;
            imm_r    <= dec_imm;
            setf_r   <= dec_setf;
            undef_r  <= dec_undef;
            unpred_r <= dec_unpred;
            cond_r   <= cond_pass;
        end
    end

    // flags: only a passing, flag-setting subtract or software writes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_r <= FLAGS_RST;
        end else if (sub_wb && setf_r) begin
            flags_r <= {dp.sum[31], dp.sum == 32'h0,
                        dp.carry, dp.ovf};             // [RULE13]
        end else if (bus_wr && sel_flags) begin
            flags_r <= avs_writedata[3:0];
        end
    end

    // word store request, held until the memory side takes it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_valid_r <= 1'b0;
            st_addr_r  <= 32'h0;
            st_data_r  <= 32'h0;
        end else if (exec && go && op_r == OP_STORE) begin
            st_valid_r <= 1'b1;
            st_addr_r  <= dp.sum;     // base plus offset only [RULE2]
            st_data_r  <= dp.rb_q;    // [RULE4]
        end else if (st_valid_r && st_ready) begin
            st_valid_r <= 1'b0;
        end
    end
    assign st_valid   = st_valid_r;
    assign st_addr    = st_addr_r;
    assign st_data    = st_data_r;
    assign st_byte_en = ALL_BYTES;    // [RULE4]
    assign st_unpriv  = 1'b1;         // never privileged, even from handler

    // result pulses; unpredictable becomes a no-op, or a trap if strict
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            done_r        <= 1'b0;
            undef_out_r   <= 1'b0;
            unpred_out_r  <= 1'b0;
            alias_vld_r   <= 1'b0;
            alias_out_r   <= AL_NONE;
            last_undef_r  <= 1'b0;
            last_unpred_r <= 1'b0;
        end else begin
            done_r <= (exec && !(go && op_r == OP_STORE))
                      || (state_r == ST_STORE && st_ready);
            undef_out_r  <= exec && (undef_r
                            || (unpred_r && ctrl_r));  // [RULE16]
            unpred_out_r <= exec && unpred_r;
            alias_vld_r  <= exec && alias_r != AL_NONE;
            alias_out_r  <= exec ? alias_r : AL_NONE;
            if (exec) begin
                last_undef_r  <= undef_r;
                last_unpred_r <= unpred_r;
            end
        end
    end
    assign instr_done  = done_r;
    assign undef_trap  = undef_out_r;
    assign unpred_seen = unpred_out_r;
    assign alias_valid = alias_vld_r;
    assign alias_kind  = alias_out_r;
    assign condition_flags_register = flags_r;

    // bus slave: issue, latch read data, then acknowledge
    logic [31:0] status_w;
    logic [31:0] rdata_nxt;
    assign status_w = {25'h0, !idle, last_unpred_r, last_undef_r, flags_r};
    assign rdata_nxt = sel_ctrl   ? {31'h0, ctrl_r} :
                       sel_status ? status_w :
                       sel_flags  ? {28'h0, flags_r} :
                       sel_gpr    ? dp.ra_q : 32'h0;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_cnt_r <= 2'h0;
            rdata_r   <= 32'h0;
            ctrl_r    <= CTRL_RST;
        end else begin
            if (idle && bus_req && !bus_ack) begin
                bus_cnt_r <= bus_cnt_r + 2'h1;
            end else begin
                bus_cnt_r <= 2'h0;
            end
            if (bus_cnt_r == 2'h1) begin
                rdata_r <= rdata_nxt;
            end
            if (bus_wr && sel_ctrl) begin
                ctrl_r <= avs_writedata[CTRL_STRICT];
            end
        end
    end
    assign avs_readdata = rdata_r;

    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_acc_st;
        acc && is_st;
    endsequence
    sequence s_exec_store;
        exec && go && op_r == OP_STORE;
    endsequence

    a_undef_base: assert property ( // [RULE1]
        s_acc_st ##0 (w_fo == REG_PC) |-> ##2 undef_trap && !st_valid)
        else $error("store with pc base not trapped");
    a_store_addr: assert property ( // [RULE2]
        s_exec_store |=> st_valid
            && st_addr == $past(dp.ra_q) + $past(imm_r))
        else $error("store address wrong");
    a_unpred_src: assert property ( // [RULE3]
        s_acc_st ##0 (w_fo != REG_PC && w_sr == REG_SP)
            |-> ##2 unpred_seen && !st_valid)
        else $error("store from sp not flagged");
    a_store_word: assert property ( // [RULE4]
        st_valid |-> st_byte_en == 4'hf && st_unpriv)
        else $error("store not full unprivileged word");
    a_store_hold: assert property ( // [RULE4]
        st_valid && !st_ready |=> st_valid && $stable(st_addr)
            && $stable(st_data))
        else $error("store request dropped or changed");
    a_block_flags: assert property ( // [RULE6] [RULE7]
        acc && (is_t1 || is_t2) && in_conditional_block
            |-> ##2 flags_r == $past(flags_r, 2))
        else $error("flags changed inside conditional block");
    a_comp_alias: assert property ( // [RULE9]
        acc && is_t3 && w_rd == REG_PC && w_s
            |-> ##2 alias_valid && alias_kind == AL_COMP)
        else $error("compare redirect missing");
    a_wide_flags: assert property ( // [RULE11]
        acc && is_t4 |-> ##2 flags_r == $past(flags_r, 2))
        else $error("wide subtract touched flags");
    a_wide_unpred: assert property ( // [RULE12]
        acc && is_t4 && w_rd == REG_SP && w_fo != REG_PC
            && w_fo != REG_SP |-> ##2 unpred_seen)
        else $error("wide subtract to sp not flagged");
    a_flag_value: assert property ( // [RULE13]
        sub_wb && setf_r |=> flags_r[FLG_Z] == ($past(dp.sum) == 32'h0)
            && flags_r[FLG_N] == $past(dp.sum[31])
            && flags_r[FLG_C] == $past(dp.carry)
            && flags_r[FLG_V] == $past(dp.ovf))
        else $error("flag result wrong");
    a_cond_fail: assert property ( // [RULE15]
        acc && !cond_pass |-> ##1 !dp.we ##1 !st_valid
            && flags_r == $past(flags_r, 2))
        else $error("failed condition updated state");
endmodule

//--- dv/usd_mem_model.sv
/*
 Memory side of the word store port: takes each store after a set
 number of stall cycles and keeps the last one taken. Assumes the
 decoder holds st_valid and its payload until st_ready is seen.
*/
`timescale 1ns/1ns
module usd_mem_model (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  stall,
    input  wire logic        st_valid,
    output logic             st_ready,
    input  wire logic [31:0] st_addr,
    input  wire logic [31:0] st_data,
    input  wire logic [3:0]  st_byte_en,
    input  wire logic        st_unpriv,
    output logic      [68:0] last_st,
    output logic      [7:0]  st_cnt
);
    logic [3:0] wait_r;

    // ready rises stall+1 cycles after valid and lasts one cycle, so a slow memory is also exercised
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_ready <= 1'b0;
            wait_r   <= 4'h0;
        end else if (st_ready) begin
            st_ready <= 1'b0;
            wait_r   <= 4'h0;
        end else if (st_valid) begin
            if (wait_r == stall)
                st_ready <= 1'b1;
            else
                wait_r <= wait_r + 4'h1;
        end
    end

    // capture at the taking edge only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_cnt <= 8'h00;
        end else if (st_valid && st_ready) begin
            st_cnt  <= st_cnt + 8'h01;
            last_st <= {st_unpriv, st_byte_en, st_addr, st_data};
        end
    end
endmodule

//--- dv/usd_top_tb_top.sv
/*
 Self-checking bench of the store and subtract decoder. Assumes the
 hand-over timing: pulses two cycles after accept, bus answers late.
*/
`timescale 1ns/1ns
module usd_top_tb_top;
    import usd_pkg::*;
    logic        core_clk = 0, rst = 1, avs_read = 0, avs_write = 0;
    logic [7:0]  avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, instr_word = 32'h0;
    logic        avs_waitrequest, instr_ready, instr_valid = 0;
    logic        instr_is32 = 0, cond_pass = 0, in_conditional_block = 0;
    logic        st_valid, st_ready, st_unpriv, instr_done, undef_trap;
    logic        unpred_seen, alias_valid;
    logic [31:0] st_addr, st_data, rd_q;
    logic [3:0]  st_byte_en, condition_flags_register, stall = 4'h2;
    usd_alias_t  alias_kind;
    logic [68:0] last_st;
    logic [7:0]  st_cnt;
    logic [5:0]  seen;
    int          bad_count = 0, check_count = 0, cyc = 0;

    usd_top dut_u (.*);
    usd_mem_model mem_u (.*);

    always #4 core_clk = ~core_clk;

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            final_report;
        end
    end

    task final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input logic [68:0] got, exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request holds until the edge that samples waitrequest low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd_q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task wreg(input logic [3:0] n, input logic [31:0] v);
        bus(1'b1, 8'h40 + {2'b00, n, 2'b00}, v);
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd_q, e);
    endtask

    // seen gathers {done, undef, unpred, alias, kind} until done
    task exec(input logic [31:0] w, input logic is32, cp, blk);
        @(posedge core_clk);
        instr_word           <= w;
        instr_is32           <= is32;
        cond_pass            <= cp;
        in_conditional_block <= blk;
        instr_valid          <= 1'b1;
        do @(posedge core_clk); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
        seen = 6'h00;
        repeat (20) begin
            @(negedge core_clk);
            seen |= {instr_done, undef_trap, unpred_seen, alias_valid,
                     alias_valid ? alias_kind : AL_NONE};
            if (instr_done === 1'b1)
                break;
        end
    endtask

    function automatic logic [35:0] sref(input logic [31:0] a, b);
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, ~b} + 33'h1;
        return {s[31], s[31:0] == 32'h0, s[32],
                (a[31] != b[31]) && (s[31] != a[31]), s[31:0]};
    endfunction

    function automatic logic [31:0] t3(input logic s,
            input logic [3:0] n, d, input logic [7:0] k);
        return {5'h1e, 2'b00, 4'hd, s, n, 4'h0, d, k};
    endfunction

    function automatic logic [31:0] t4(input logic [3:0] n, d,
            input logic [11:0] k);
        return {5'h1e, k[11], 5'h15, 1'b0, n, 1'b0, k[10:8], d, k[7:0]};
    endfunction

    // flags preset to 5 so an untouched flag set is visible
    task sub_case(input logic [31:0] w, input logic is32, blk, sf,
                  input logic [3:0] n, d, input logic [31:0] a, b);
        logic [35:0] r;
        r = sref(a, b);
        bus(1'b1, OFF_FLAGS, 32'h5);
        wreg(n, a);
        exec(w, is32, 1'b1, blk);
        chk(seen, 6'h20);
        rchk(8'h40 + {2'b00, d, 2'b00}, r[31:0]);
        rchk(OFF_FLAGS, sf ? {28'h0, r[35:32]} : 32'h5);
        chk(condition_flags_register, sf ? r[35:32] : 4'h5);
    endtask

    task t_store;
        logic [7:0] c;
        stall = 4'h4;
        wreg(1, 32'h1000_0f00);
        wreg(2, 32'hdead_beef);
        exec({12'hf84, 4'h1, 4'h2, 4'he, 8'hff}, 1'b1, 1'b1, 1'b0);
        chk(seen, 6'h20);
        chk(last_st, {1'b1, 4'hf, 32'h1000_0fff, 32'hdead_beef});
        stall = 4'h0;
        wreg(13, 32'h2000_0000);
        exec({12'hf84, 4'hd, 4'h1, 4'he, 8'h00}, 1'b1, 1'b1, 1'b0);
        chk(last_st, {1'b1, 4'hf, 32'h2000_0000, 32'h1000_0f00});
        c = st_cnt;
        exec({12'hf84, 4'h1, 4'h2, 4'he, 8'h04}, 1'b1, 1'b0, 1'b0);
        chk(st_cnt, c);
        exec({12'hf84, 4'hf, 4'h2, 4'he, 8'h04}, 1'b1, 1'b1, 1'b0);
        chk(seen, 6'h30);
        exec({12'hf84, 4'h1, 4'hd, 4'he, 8'h04}, 1'b1, 1'b1, 1'b0);
        chk(seen, 6'h28);
        exec({12'hf84, 4'h1, 4'hf, 4'he, 8'h04}, 1'b1, 1'b1, 1'b0);
        chk(seen, 6'h28);
        chk(st_cnt, c);
    endtask

    task t_sub;
        sub_case({7'h0f, 3'h7, 3'h3, 3'h4, 16'h0}, 0, 0, 1, 3, 4, 5, 7);
        sub_case({7'h0f, 3'h7, 3'h3, 3'h4, 16'h0}, 0, 1, 0, 3, 4, 32'h8000_0000, 7);
        exec({7'h0f, 3'h1, 3'h3, 3'h4, 16'h0}, 1'b0, 1'b0, 1'b0);
        rchk(8'h50, 32'h7fff_fff9);
        sub_case({5'h07, 3'h5, 8'hff, 16'h0}, 0, 0, 1, 5, 5, 32'hff, 255);
        sub_case(t3(1, 6, 7, 8'h01), 1, 0, 1, 6, 7, 32'h8000_0000, 1);
        sub_case(t3(0, 6, 7, 8'h01), 1, 0, 0, 6, 7, 32'h3, 1);
        sub_case(t4(1, 8, 12'hfff), 1, 0, 0, 1, 8, 32'h1000, 4095);
        exec(t3(1, 1, 15, 8'h01), 1'b1, 1'b1, 1'b0);
        chk(seen, 6'h25);
        exec(t3(0, 13, 1, 8'h01), 1'b1, 1'b1, 1'b0);
        chk(seen, 6'h26);
        exec(t3(1, 1, 13, 8'h01), 1'b1, 1'b1, 1'b0);
        chk(seen, 6'h28);
        exec(t3(0, 1, 15, 8'h01), 1'b1, 1'b1, 1'b0);
        chk(seen, 6'h28);
        exec(t3(1, 15, 1, 8'h01), 1'b1, 1'b1, 1'b0);
        chk(seen, 6'h28);
        exec(t4(15, 1, 12'h001), 1'b1, 1'b1, 1'b0);
        chk(seen, 6'h27);
        exec(t4(13, 1, 12'h001), 1'b1, 1'b1, 1'b0);
        chk(seen, 6'h26);
        exec(t4(1, 13, 12'h001), 1'b1, 1'b1, 1'b0);
        chk(seen, 6'h28);
        exec(t4(1, 15, 12'h001), 1'b1, 1'b1, 1'b0);
        chk(seen, 6'h28);
        bus(1'b1, OFF_CTRL, 32'h1);
        exec({12'hf84, 4'h1, 4'hd, 4'he, 8'h04}, 1'b1, 1'b1, 1'b0);
        chk(seen, 6'h38);
        rchk(OFF_STATUS, 32'h25);
        rchk(8'hc0, 32'h0);
    endtask

    // reset for four cycles, released on an edge
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_store;
        t_sub;
        final_report;
    end
endmodule
